// ===== rtl/hrr_pkg.sv
// shared types and constants for the hard row repair block
package hrr_pkg;

	typedef enum logic [2:0] {
		CMD_DES   = 3'b000,
		CMD_MRS   = 3'b001,
		CMD_ACT   = 3'b010,
		CMD_WR    = 3'b011,
		CMD_PRE   = 3'b100,
		CMD_REF   = 3'b101,
		CMD_RD    = 3'b110,
		CMD_OTHER = 3'b111
	} cmd_e;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_KEYS    = 3'b001,
		ST_ARMED   = 3'b010,
		ST_OPEN    = 3'b011,
		ST_BURST   = 3'b100,
		ST_PROGRAM = 3'b101,
		ST_RECOG   = 3'b110,
		ST_VOID    = 3'b111
	} state_e;

	localparam int         ADDR_W          = 18;
	localparam logic [2:0] MR_SEL_MR0      = 3'h0;
	localparam logic [2:0] MR_SEL_MR4      = 3'h4;
	localparam int         MR4_REPAIR_BIT  = 13;
	localparam int         NUM_KEYS        = 4;
	localparam int         KEY_W           = 5;
	localparam int         KEY_LSB         = 7;
	localparam int         KEY_LOW_W       = 7;
	localparam logic [6:0] KEY_LOW_ONES    = 7'h7F;
	localparam logic [1:0] KEY_BG          = 2'h0;
	localparam logic [1:0] KEY_BA          = 2'h0;
	// key n sits at [n*KEY_W +: KEY_W], fields A11..A7
	localparam logic [19:0] GUARD_KEYS     = {5'h07, 5'h17, 5'h0F, 5'h19};
	localparam logic [1:0] LAST_KEY_IDX    = 2'h3;
	localparam int         BURST_CLOCKS    = 4;
	localparam int         HIGH_RUN_MIN    = 2;
	localparam state_e     STATE_RESET     = ST_IDLE;

endpackage

// ===== rtl/burst_check_if.sv
// carrier between repair sequencer and burst checker
`timescale 1ns/10ps
interface burst_check_if;
	logic start;
	logic done;
	logic allLow;
	logic highRun;
	modport ctrl (output start, input done, input allLow, input highRun);
	modport chk  (input start, output done, output allLow, output highRun);
endinterface

// ===== rtl/hrr_burst_check.sv
// judges the eight beats of the repair write burst
`timescale 1ns/10ps
module hrr_burst_check #(
	parameter int DQ_W = 8,
	parameter int WL   = 9
) (
	input  wire logic            clk,
	input  wire logic            resetn,
	burst_check_if.chk           bc,
	input  wire logic [DQ_W-1:0] dqRise,
	input  wire logic [DQ_W-1:0] dqFall
);
	import hrr_pkg::*;

	localparam int              CW         = $clog2(WL + BURST_CLOCKS + 1);
	localparam logic [CW-1:0]   FIRST_C    = CW'(WL);
	localparam logic [CW-1:0]   LAST_C     = CW'(WL + BURST_CLOCKS - 1);
	localparam logic [1:0]      RUN_HIT_C  = 2'(HIGH_RUN_MIN - 1);
	localparam int              DONE_DELAY = WL + BURST_CLOCKS;

	logic [CW-1:0] cnt_r;
	logic [1:0]    runLen_r;
	logic          anyHigh_r;
	logic          seenRun_r;
	logic          done_r;
	logic          allLow_r;
	logic          highRun_r;
	logic          window;
	logic          highNow;
	logic          allHighNow;
	logic          runHit;

	assign window     = (cnt_r >= FIRST_C) && (cnt_r <= LAST_C);
	assign highNow    = (|dqRise) | (|dqFall);
	assign allHighNow = (&dqRise) & (&dqFall);
	assign runHit     = allHighNow && (runLen_r >= RUN_HIT_C);

	// latency counter, cycle k after the write is sampled at cnt_r == k
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
		end else if (cnt_r == '0) begin
			if (bc.start) begin
				cnt_r <= CW'(1);
			end
		end else if (cnt_r == LAST_C) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + CW'(1);
		end
	end

	// any high bit anywhere in the burst vetoes the repair
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			anyHigh_r <= 1'b0;
		end else if (bc.start && cnt_r == '0) begin
			anyHigh_r <= 1'b0;
		end else if (window && highNow) begin
			anyHigh_r <= 1'b1;
		end
	end

	// run of clocks with every bit high on both edges
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			runLen_r  <= '0;
			seenRun_r <= 1'b0;
		end else if (bc.start && cnt_r == '0) begin
			runLen_r  <= '0;
			seenRun_r <= 1'b0;
		end else if (window) begin
			runLen_r  <= allHighNow ? ((runLen_r == 2'h3) ? runLen_r : runLen_r + 2'h1) : 2'h0;
			seenRun_r <= seenRun_r | runHit;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			done_r    <= 1'b0;
			allLow_r  <= 1'b0;
			highRun_r <= 1'b0;
		end else begin
			done_r <= window && (cnt_r == LAST_C);
			if (window && (cnt_r == LAST_C)) begin
				allLow_r  <= !(anyHigh_r | highNow);
				highRun_r <= seenRun_r | runHit;
			end
		end
	end

	assign bc.done    = done_r;
	assign bc.allLow  = allLow_r;
	assign bc.highRun = highRun_r;

	property p_done_time;
		@(posedge clk) disable iff (!resetn)
		(bc.start && cnt_r == '0) |-> ##DONE_DELAY bc.done;
	endproperty
	a_done_time: assert property (p_done_time) else $error("burst verdict not on time");

	property p_high_blocks;
		@(posedge clk) disable iff (!resetn)
		(window && highNow) |-> ##[1:8] (bc.done && !bc.allLow);
	endproperty
	a_high_blocks: assert property (p_high_blocks) else $error("high bit did not veto repair");

	property p_run_skips;
		@(posedge clk) disable iff (!resetn)
		(bc.done && bc.highRun) |-> !bc.allLow;
	endproperty
	a_run_skips: assert property (p_run_skips) else $error("high run still flagged all low");

endmodule

// ===== rtl/dram_hard_row_repair_wr.sv
// device side of the write-initiated hard row repair sequence
// Function
// - mode register 4 bit 13 set enters repair mode; all DQ driven high until the write, or until a broken sequence voids the repair.
// - four mode register 0 guard keys in order, low address bits all ones.
// - wrong or interrupted keys disable repair; programming becomes a no-operation.
// - plain write to same bank; column value ignored by the device.
// - repair starts only when all sampled burst bits are low.
// - any high bit in the burst blocks repair of this device.
// - two or more all-high clocks skip repair; mixed patterns undefined.
// - whole sequence may repeat once per repaired row.
`timescale 1ns/10ps
module dram_hard_row_repair_wr #(
	parameter int DQ_W = 8,
	parameter int CWL  = 9,
	parameter int AL   = 0,
	parameter int PL   = 0
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire hrr_pkg::cmd_e         cmd,
	input  wire logic [1:0]            bg,
	input  wire logic [1:0]            ba,
	input  wire logic [hrr_pkg::ADDR_W-1:0] addr,
	input  wire logic [DQ_W-1:0]       dqRise,
	input  wire logic [DQ_W-1:0]       dqFall,
	output logic [DQ_W-1:0]            dqOut,
	output logic                       dqOe,
	output logic                       modeOn,
	output logic                       keysAccepted,
	output logic                       programming,
	output logic                       repairCommitted,
	output logic                       repairSkipped,
	output logic                       patternUndefined,
	output logic                       repairedValid,
	output logic [1:0]                 repairedBg,
	output logic [1:0]                 repairedBa,
	output logic [hrr_pkg::ADDR_W-1:0] repairedRow
);
	import hrr_pkg::*;

	localparam int WL = CWL + AL + PL;

	state_e              st_r;
	state_e              st_nxt;
	logic [1:0]          keyIdx_r;
	logic [1:0]          tgtBg_r;
	logic [1:0]          tgtBa_r;
	logic [ADDR_W-1:0]   tgtRow_r;
	logic [DQ_W-1:0]     dqOut_r;
	logic                dqOe_r;
	logic                modeOn_r;
	logic                keysAccepted_r;
	logic                programming_r;
	logic                repairCommitted_r;
	logic                repairSkipped_r;
	logic                patternUndefined_r;
	logic                repairedValid_r;
	logic [1:0]          repairedBg_r;
	logic [1:0]          repairedBa_r;
	logic [ADDR_W-1:0]   repairedRow_r;
	logic                isMr4;
	logic                mr4Set;
	logic                mr4Clr;
	logic                keyHit;
	logic                wrHit;
	logic [KEY_W-1:0]    keyExpect;

	burst_check_if bc ();

	hrr_burst_check #(
		.DQ_W (DQ_W),
		.WL   (WL)
	) u_check (
		.clk    (clk),
		.resetn (resetn),
		.bc     (bc.chk),
		.dqRise (dqRise),
		.dqFall (dqFall)
	);

	assign isMr4     = (cmd == CMD_MRS) && ({bg[0], ba} == MR_SEL_MR4);
	assign mr4Set    = isMr4 && addr[MR4_REPAIR_BIT];
	assign mr4Clr    = isMr4 && !addr[MR4_REPAIR_BIT];
	assign keyExpect = GUARD_KEYS[int'(keyIdx_r)*KEY_W +: KEY_W];
	assign keyHit    = (cmd == CMD_MRS) && ({bg[0], ba} == MR_SEL_MR0) && (bg == KEY_BG) && (ba == KEY_BA)
		&& (addr[KEY_LSB +: KEY_W] == keyExpect) && (addr[KEY_LOW_W-1:0] == KEY_LOW_ONES);
	// column address deliberately not compared
	assign wrHit     = (cmd == CMD_WR) && (bg == tgtBg_r) && (ba == tgtBa_r);
	assign bc.start  = (st_r == ST_OPEN) && wrHit;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (mr4Set) begin
					st_nxt = ST_KEYS;
				end
			end
			ST_KEYS: begin
				if (mr4Clr) begin
					st_nxt = ST_IDLE;
				end else if (keyHit) begin
					st_nxt = (keyIdx_r == LAST_KEY_IDX) ? ST_ARMED : ST_KEYS;
				end else if (cmd != CMD_DES) begin
					st_nxt = ST_VOID;
				end
			end
			ST_ARMED: begin
				if (mr4Clr) begin
					st_nxt = ST_IDLE;
				end else if (cmd == CMD_ACT) begin
					st_nxt = ST_OPEN;
				end else if (cmd != CMD_DES) begin
					st_nxt = ST_VOID;
				end
			end
			ST_OPEN: begin
				if (mr4Clr) begin
					st_nxt = ST_IDLE;
				end else if (wrHit) begin
					st_nxt = ST_BURST;
				end else if (cmd != CMD_DES) begin
					// refresh or a stray command here would upset the target row
					st_nxt = ST_VOID;
				end
			end
			ST_BURST: begin
				if (bc.done) begin
					st_nxt = bc.allLow ? ST_PROGRAM : ST_VOID;
				end
			end
			ST_PROGRAM: begin
				// programming time is the controller's to honour
				if (cmd == CMD_PRE) begin
					st_nxt = ST_RECOG;
				end
			end
			ST_RECOG: begin
				if (mr4Clr) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_VOID: begin
				if (mr4Clr) begin
					st_nxt = ST_IDLE;
				end
			end
			default: begin
				st_nxt = STATE_RESET;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= STATE_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			keyIdx_r <= '0;
		end else if (st_r != ST_KEYS) begin
			keyIdx_r <= '0;
		end else if (keyHit && keyIdx_r != LAST_KEY_IDX) begin
			keyIdx_r <= keyIdx_r + 2'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tgtBg_r  <= '0;
			tgtBa_r  <= '0;
			tgtRow_r <= '0;
		end else if (st_r == ST_ARMED && cmd == CMD_ACT && !mr4Clr) begin
			tgtBg_r  <= bg;
			tgtBa_r  <= ba;
			tgtRow_r <= addr;
		end
	end

	// entry drives all DQ high; the write hands the bus to the controller
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dqOut_r <= '0;
			dqOe_r  <= 1'b0;
		end else begin
			dqOut_r <= '1;
			dqOe_r  <= (st_nxt == ST_KEYS) || (st_nxt == ST_ARMED) || (st_nxt == ST_OPEN);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			modeOn_r       <= 1'b0;
			keysAccepted_r <= 1'b0;
			programming_r  <= 1'b0;
		end else begin
			modeOn_r       <= st_nxt != ST_IDLE;
			keysAccepted_r <= (st_nxt == ST_ARMED) || (st_nxt == ST_OPEN) || (st_nxt == ST_BURST)
				|| (st_nxt == ST_PROGRAM) || (st_nxt == ST_RECOG);
			programming_r  <= st_nxt == ST_PROGRAM;
		end
	end

	// mixed patterns are treated as a skip; safer than a half repair
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			repairSkipped_r    <= 1'b0;
			patternUndefined_r <= 1'b0;
		end else begin
			repairSkipped_r    <= (st_r == ST_BURST) && bc.done && !bc.allLow;
			patternUndefined_r <= (st_r == ST_BURST) && bc.done && !bc.allLow && !bc.highRun;
		end
	end

	// row is registered on the precharge; kept until the next repair
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			repairCommitted_r <= 1'b0;
			repairedValid_r   <= 1'b0;
			repairedBg_r      <= '0;
			repairedBa_r      <= '0;
			repairedRow_r     <= '0;
		end else begin
			repairCommitted_r <= (st_r == ST_PROGRAM) && (cmd == CMD_PRE);
			if ((st_r == ST_PROGRAM) && (cmd == CMD_PRE)) begin
				repairedValid_r <= 1'b1;
				repairedBg_r    <= tgtBg_r;
				repairedBa_r    <= tgtBa_r;
				repairedRow_r   <= tgtRow_r;
			end
		end
	end

	assign dqOut            = dqOut_r;
	assign dqOe             = dqOe_r;
	assign modeOn           = modeOn_r;
	assign keysAccepted     = keysAccepted_r;
	assign programming      = programming_r;
	assign repairCommitted  = repairCommitted_r;
	assign repairSkipped    = repairSkipped_r;
	assign patternUndefined = patternUndefined_r;
	assign repairedValid    = repairedValid_r;
	assign repairedBg       = repairedBg_r;
	assign repairedBa       = repairedBa_r;
	assign repairedRow      = repairedRow_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_enter;
		(st_r == ST_IDLE) && mr4Set;
	endsequence
	sequence s_driving;
		modeOn_r && dqOe_r && (dqOut_r == '1) && !keysAccepted_r;
	endsequence
	property p_entry;
		s_enter |=> s_driving;
	endproperty
	a_entry: assert property (p_entry) else $error("entry did not drive DQ high");

	property p_key_step;
		(st_r == ST_KEYS) && keyHit && !mr4Clr && (keyIdx_r != LAST_KEY_IDX) |=> keyIdx_r == $past(keyIdx_r) + 2'h1;
	endproperty
	a_key_step: assert property (p_key_step) else $error("guard key index did not advance");

	property p_key_last;
		(st_r == ST_KEYS) && keyHit && !mr4Clr && (keyIdx_r == LAST_KEY_IDX) |=> keysAccepted_r && st_r == ST_ARMED;
	endproperty
	a_key_last: assert property (p_key_last) else $error("fourth key not accepted");

	property p_key_bad;
		(st_r == ST_KEYS) && !keyHit && !isMr4 && (cmd != CMD_DES) |=> (st_r == ST_VOID) && !keysAccepted_r;
	endproperty
	a_key_bad: assert property (p_key_bad) else $error("broken key sequence not voided");

	property p_void_holds;
		(st_r == ST_VOID) && !mr4Clr |=> (st_r == ST_VOID) && !programming_r && !repairCommitted_r;
	endproperty
	a_void_holds: assert property (p_void_holds) else $error("voided sequence started a repair");

	sequence s_write;
		(st_r == ST_OPEN) && wrHit && !mr4Clr;
	endsequence
	property p_write_release;
		s_write |=> (st_r == ST_BURST) && !dqOe_r;
	endproperty
	a_write_release: assert property (p_write_release) else $error("write did not release DQ");

	property p_repair_start;
		(st_r == ST_BURST) && bc.done && bc.allLow |=> programming_r ##1 (programming_r || repairCommitted_r);
	endproperty
	a_repair_start: assert property (p_repair_start) else $error("all-low burst did not start repair");

	property p_repair_skip;
		(st_r == ST_BURST) && bc.done && !bc.allLow |=> repairSkipped_r && !programming_r && (st_r == ST_VOID);
	endproperty
	a_repair_skip: assert property (p_repair_skip) else $error("high burst did not skip repair");

	property p_commit;
		(st_r == ST_PROGRAM) && (cmd == CMD_PRE) |=> repairCommitted_r && repairedValid_r
			&& (repairedRow_r == $past(tgtRow_r)) ##1 !repairCommitted_r;
	endproperty
	a_commit: assert property (p_commit) else $error("precharge did not register the row");

	property p_exit;
		modeOn_r && mr4Clr && (st_r != ST_BURST) && (st_r != ST_PROGRAM) |=> !modeOn_r && !dqOe_r;
	endproperty
	a_exit: assert property (p_exit) else $error("mode disable did not leave repair mode");

endmodule

// ===== verification/hrr_ctrl_model.sv
// controller-side partner driving commands and repair burst data
`timescale 1ns/10ps
module hrr_ctrl_model #(
	parameter int                        DQ_W      = 8,
	parameter int                        WL        = 9,
	parameter logic [hrr_pkg::ADDR_W-1:0] MR0_SAVED = 18'h00A34
) (
	input  wire logic                  clk,
	output hrr_pkg::cmd_e              cmd,
	output logic [1:0]                 bg,
	output logic [1:0]                 ba,
	output logic [hrr_pkg::ADDR_W-1:0] addr,
	output logic [DQ_W-1:0]            dqRise,
	output logic [DQ_W-1:0]            dqFall
);
	import hrr_pkg::*;
	// programming wait shortened, device does not time it
	localparam int PGM_CYC   = 16;
	localparam int PEXIT_CYC = (15 + 7) / 8;
	localparam int PST_CYC   = (50000 + 7) / 8;

	initial begin
		cmd    = CMD_DES;
		bg     = 2'h0;
		ba     = 2'h0;
		addr   = '0;
		dqRise = '0;
		dqFall = '0;
	end

	// released lines show the inverse so stale values cannot pass
	task automatic issue(input cmd_e c, input logic [1:0] g, input logic [1:0] b, input logic [ADDR_W-1:0] a);
		@(posedge clk);
		#1;
		cmd  = c;
		bg   = g;
		ba   = b;
		addr = a;
		@(posedge clk);
		#1;
		cmd  = CMD_DES;
		bg   = ~g;
		ba   = ~b;
		addr = ~a;
	endtask

	task automatic mr4(input logic on);
		logic [ADDR_W-1:0] a;
		a = '0;
		a[MR4_REPAIR_BIT] = on;
		issue(CMD_MRS, {1'b0, MR_SEL_MR4[2]}, MR_SEL_MR4[1:0], a);
	endtask

	task automatic keys(input logic swap);
		logic [ADDR_W-1:0] a;
		int                j;
		for (int i = 0; i < NUM_KEYS; i++) begin
			j = (swap && i < 2) ? 1 - i : i;
			a = '0;
			a[KEY_LSB +: KEY_W] = GUARD_KEYS[j*KEY_W +: KEY_W];
			a[KEY_LOW_W-1:0] = KEY_LOW_ONES;
			issue(CMD_MRS, KEY_BG, KEY_BA, a);
		end
	endtask

	// strobe not modelled: each clock carries its rise and fall beat
	task automatic repair(input logic [1:0] g, input logic [1:0] b, input logic [ADDR_W-1:0] row,
			input logic [7:0][DQ_W-1:0] bits);
		issue(CMD_ACT, g, b, row);
		issue(CMD_WR, g, b, '0);
		repeat (WL - 1) @(posedge clk);
		for (int k = 0; k < 4; k++) begin
			#1;
			dqRise = bits[2*k];
			dqFall = bits[2*k+1];
			@(posedge clk);
		end
		#1;
		dqRise = ~bits[6];
		dqFall = ~bits[7];
	endtask

	task automatic precharge(input logic [1:0] g, input logic [1:0] b);
		repeat (PGM_CYC) @(posedge clk);
		issue(CMD_PRE, g, b, '0);
	endtask

	task automatic leave();
		repeat (PEXIT_CYC) @(posedge clk);
		mr4(1'b0);
		repeat (PST_CYC) @(posedge clk);
		issue(CMD_MRS, 2'h0, 2'h0, MR0_SAVED);
	endtask
endmodule

// ===== verification/tb_dram_hard_row_repair_wr.sv
// self-checking bench for the hard row repair block
`timescale 1ns/10ps
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin errTotal++; \
	$display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end
module tb_dram_hard_row_repair_wr;
	import hrr_pkg::*;
	localparam int               DQ_W     = 8;
	localparam int               CWL      = 9;
	// nonzero additive and parity latency, so the latency sum is exercised
	localparam int               AL       = 1;
	localparam int               PL       = 1;
	localparam int               WL       = CWL + AL + PL;
	localparam logic [ADDR_W-1:0] LAST_ROW = 18'h1F00E;
	logic                clk;
	logic                resetn;
	cmd_e                cmd;
	logic [1:0]          bg;
	logic [1:0]          ba;
	logic [ADDR_W-1:0]   addr;
	logic [DQ_W-1:0]     dqRise;
	logic [DQ_W-1:0]     dqFall;
	logic [DQ_W-1:0]     dqOut;
	logic                dqOe;
	logic                modeOn;
	logic                keysAccepted;
	logic                programming;
	logic                repairCommitted;
	logic                repairSkipped;
	logic                patternUndefined;
	logic                repairedValid;
	logic [1:0]          repairedBg;
	logic [1:0]          repairedBa;
	logic [ADDR_W-1:0]   repairedRow;
	int                  errTotal;
	int                  testsRun;

	dram_hard_row_repair_wr #(.DQ_W(DQ_W), .CWL(CWL), .AL(AL), .PL(PL)) dut (
		.clk(clk), .resetn(resetn), .cmd(cmd), .bg(bg), .ba(ba), .addr(addr),
		.dqRise(dqRise), .dqFall(dqFall), .dqOut(dqOut), .dqOe(dqOe), .modeOn(modeOn),
		.keysAccepted(keysAccepted), .programming(programming), .repairCommitted(repairCommitted),
		.repairSkipped(repairSkipped), .patternUndefined(patternUndefined), .repairedValid(repairedValid),
		.repairedBg(repairedBg), .repairedBa(repairedBa), .repairedRow(repairedRow)
	);

	hrr_ctrl_model #(.DQ_W(DQ_W), .WL(WL)) ctl (
		.clk(clk), .cmd(cmd), .bg(bg), .ba(ba), .addr(addr), .dqRise(dqRise), .dqFall(dqFall)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// sel 0: burst verdict, sel 1: commit pulse
	task automatic waitHigh(input int sel);
		int n;
		n = 0;
		#1;
		while (((sel == 0) ? (programming | repairSkipped) : repairCommitted) !== 1'b1 && n < 12) begin
			@(posedge clk);
			#2;
			n++;
		end
	endtask

	task automatic t_reset();
		`CHK(modeOn, 1'b0)
		`CHK(dqOe, 1'b0)
		`CHK(repairedValid, 1'b0)
		#1;
		resetn = 1'b1;
	endtask

	task automatic t_repair(input logic [1:0] g, input logic [1:0] b, input logic [ADDR_W-1:0] row);
		ctl.mr4(1'b1);
		#1;
		`CHK(modeOn, 1'b1)
		`CHK(dqOe, 1'b1)
		`CHK(dqOut, {DQ_W{1'b1}})
		ctl.keys(1'b0);
		#1;
		`CHK(keysAccepted, 1'b1)
		ctl.repair(g, b, row, 64'h0);
		`CHK(dqOe, 1'b0)
		waitHigh(0);
		`CHK(programming, 1'b1)
		`CHK(repairSkipped, 1'b0)
		ctl.precharge(g, b);
		waitHigh(1);
		`CHK(repairCommitted, 1'b1)
		`CHK(repairedRow, row)
		`CHK(repairedBg, g)
		`CHK(repairedBa, b)
		`CHK(repairedValid, 1'b1)
		@(posedge clk);
		#2;
		`CHK(repairCommitted, 1'b0)
		`CHK(programming, 1'b0)
		ctl.leave();
		#1;
		`CHK(modeOn, 1'b0)
		`CHK(keysAccepted, 1'b0)
		`CHK(repairedRow, row)
	endtask

	task automatic t_badkeys();
		ctl.mr4(1'b1);
		ctl.keys(1'b1);
		#1;
		`CHK(keysAccepted, 1'b0)
		ctl.repair(2'h0, 2'h3, 18'h00777, 64'h0);
		waitHigh(0);
		`CHK(programming, 1'b0)
		`CHK(repairSkipped, 1'b0)
		`CHK(repairedRow, LAST_ROW)
		ctl.leave();
	endtask

	task automatic t_skip(input logic [63:0] bits, input logic undef);
		ctl.mr4(1'b1);
		ctl.keys(1'b0);
		ctl.repair(2'h2, 2'h1, 18'h00333, bits);
		waitHigh(0);
		`CHK(repairSkipped, 1'b1)
		`CHK(patternUndefined, undef)
		`CHK(programming, 1'b0)
		@(posedge clk);
		#2;
		`CHK(repairSkipped, 1'b0)
		ctl.leave();
		`CHK(repairedRow, LAST_ROW)
	endtask

	// deliberate refresh while the target row is open
	task automatic t_refresh();
		ctl.mr4(1'b1);
		ctl.keys(1'b0);
		ctl.issue(CMD_ACT, 2'h1, 2'h1, 18'h00123);
		ctl.issue(CMD_REF, 2'h1, 2'h1, 18'h00000);
		#1;
		`CHK(keysAccepted, 1'b0)
		ctl.leave();
		`CHK(modeOn, 1'b0)
	endtask

	initial begin
		errTotal = 0;
		testsRun = 0;
		resetn   = 1'b0;
		repeat (20) @(posedge clk);
		t_reset();
		t_repair(2'h1, 2'h2, 18'h2A5C3);
		t_repair(2'h3, 2'h0, LAST_ROW);
		t_badkeys();
		t_skip(64'h0000_0000_0100_0000, 1'b1);
		t_skip(64'h0000_0000_FFFF_FFFF, 1'b0);
		t_skip(64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
		t_refresh();
		complete_run();
	end

	// seven exit waits of 6250 cycles need about 45k cycles; 75k leaves margin
	initial begin
		#600000;
		errTotal++;
		$display("[FAIL] %0t watchdog expired", $time);
		complete_run();
	end
endmodule
